// ==== common/rif_pkg.sv ====
// receive input formatter: shared constants, field layouts and carriers
// assumes a single 250 MHz chip clock and plain configuration ports, no register bus
`default_nettype none

package rif_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned RIF_NCH = 4;
  localparam int unsigned RIF_DW = 16;
  localparam int unsigned RIF_SELW = 3;
  localparam int unsigned RIF_DIAGW = 2;
  localparam int unsigned RIF_ZPW = 4;
  localparam int unsigned RIF_MASKW = 12;
  localparam int unsigned RIF_CKSW = 2;
  localparam int unsigned RIF_SYNC_DLY = 2;
  localparam int unsigned RIF_FIFO_DEPTH = 4;

  // ==========================================================
  // source selector codes
  localparam logic [RIF_SELW-1:0] RIF_SEL_OFF = 3'h0;
  localparam logic [RIF_SELW-1:0] RIF_SEL_IMAG = 3'h1;
  localparam logic [RIF_SELW-1:0] RIF_SEL_DIAG = 3'h2;
  localparam logic [RIF_SELW-1:0] RIF_SEL_MUX = 3'h3;
  localparam logic [RIF_SELW-1:0] RIF_SEL_REAL = 3'h4;

  // diagnostic source codes
  localparam logic [RIF_DIAGW-1:0] RIF_DIAG_RAMP = 2'h0;
  localparam logic [RIF_DIAGW-1:0] RIF_DIAG_ZERO = 2'h1;
  localparam logic [RIF_DIAGW-1:0] RIF_DIAG_CONST = 2'h2;
  localparam logic [RIF_DIAGW-1:0] RIF_DIAG_PN = 2'h3;

  // ==========================================================
  // values
  localparam logic [RIF_DW-1:0] RIF_CONST_VAL = 16'h4000;
  localparam logic [RIF_DW-1:0] RIF_LFSR_SEED = 16'h0001;
  localparam logic [RIF_DW-1:0] RIF_LFSR_TAPS = 16'hb400;
  localparam logic [RIF_DW-1:0] RIF_RAMP_STEP = 16'h0001;
  localparam logic [RIF_CKSW-1:0] RIF_CKS_RUN = 2'h0;
  localparam logic [RIF_ZPW-1:0] RIF_ZCNT_TERM = 4'h0;
  localparam logic [RIF_ZPW-1:0] RIF_ZCNT_STEP = 4'h1;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [RIF_DW-1:0] i;
    logic [RIF_DW-1:0] q;
  } rif_iq_t;

  typedef struct packed {
    logic [RIF_SELW-1:0] sel;
    logic [RIF_DIAGW-1:0] diag;
    logic [RIF_ZPW-1:0] zpad;
    logic zsync_src;
    logic [RIF_MASKW-1:0] noise_mask;
  } rif_chcfg_t;

  typedef struct packed {
    rif_iq_t [RIF_NCH-1:0] iq;
    logic [RIF_NCH-1:0] vld;
  } rif_word_t;

  localparam int unsigned RIF_WORD_W = $bits(rif_word_t);

endpackage : rif_pkg

`default_nettype wire

// ==== hw/rif_fifo.sv ====
// small first-word-fall-through fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset and a clock enable freezing it
`default_nettype none

module rif_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_st_t;

  fifo_st_t st_reg;
  fifo_st_t st_next;
  logic push;
  logic pop;

  // ==========================================================
  // handshake
  assign in_ready_o = ce_i && (st_reg.count != CNT_FULL);
  assign out_valid_o = ce_i && (st_reg.count != '0);
  assign out_data_o = st_reg.mem[st_reg.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data_i;
      st_next.wr_ptr = (st_reg.wr_ptr == PTR_LAST) ? '0 : st_reg.wr_ptr + AW'(1);
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == PTR_LAST) ? '0 : st_reg.rd_ptr + AW'(1);
    end
    case ({push, pop})
      2'b10: st_next.count = st_reg.count + (AW + 1)'(1);
      2'b01: st_next.count = st_reg.count - (AW + 1)'(1);
      default: st_next.count = st_reg.count;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

endmodule // rif_fifo

`default_nettype wire

// ==== hw/rif_formatter.sv ====
// four-port receive input formatter: real/complex/multiplexed input to per-port I/Q buses
// assumes raw pins on the input ports and syncs, a 250 MHz clock, and a downstream
// consumer that drains the output fifo with valid/ready
`default_nettype none

// Behaviour
// RULE_01: each of four ports gets its own formatter producing 16-bit I and Q.
// RULE_02: without a valid sample, both I and Q buses are driven to zero.
// RULE_03: five input formats supported through selector, pairing and zero insertion.
// RULE_04: full-rate real puts port data on I, Q held zero.
// RULE_05: half-rate complex zeroes every second time sample.
// RULE_06: full-rate complex: A/C feed I with Q zero, B/D feed Q with I zero.
// RULE_07: four-complex uses selector 3 per port; four-real uses selector 4.
// RULE_08: multiplexed mode: I is port data delayed one clock, Q undelayed.
// RULE_09: multiplexed mode zeroes every other pair via the interpolation logic.
// RULE_10: programmable 0 to 15 zeros inserted between kept samples.
// RULE_11: exactly one sample per period kept, the rest replaced by zero.
// RULE_12: sync delayed two clocks loads counter; terminal count reloads and keeps.
// RULE_13: kept sample arrives two plus zpad plus one clocks after sync.
// RULE_14: sync may be single or periodic at multiples of zpad plus one.
// RULE_15: source asserts sync together with the quadrature sample when multiplexed.
// RULE_16: masked input bits are xored with the pseudo-random noise sequence.
// RULE_17: noise mask spans 0xfff down to 0x1.
// RULE_18: noise generator runs only while its checksum sync field is zero.
// RULE_19: diagnostics replace the real input with ramp, zero, constant or noise.
// RULE_20: diagnostic constant value is 0x4000.
// RULE_21: sync inputs are active low and idle high.
// RULE_22: settings change only while the channel is idle or resynchronising.
module rif_formatter #(
  parameter int unsigned FIFO_DEPTH = rif_pkg::RIF_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [rif_pkg::RIF_DW-1:0] input_port_a_i,
  input wire logic [rif_pkg::RIF_DW-1:0] input_port_b_i,
  input wire logic [rif_pkg::RIF_DW-1:0] input_port_c_i,
  input wire logic [rif_pkg::RIF_DW-1:0] input_port_d_i,
  input wire logic sync_input_a_n_i,
  input wire logic sync_input_b_n_i,
  input wire rif_pkg::rif_chcfg_t [rif_pkg::RIF_NCH-1:0] ch_cfg_i,
  input wire logic [rif_pkg::RIF_CKSW-1:0] cksum_sync_front_i,
  output logic stall_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output rif_pkg::rif_word_t out_word_o
);

  import rif_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [RIF_NCH-1:0][RIF_DW-1:0] pin_s1;
    logic [RIF_NCH-1:0][RIF_DW-1:0] pin_s2;
    logic [1:0] sync_s1;
    logic [1:0] sync_s2;
    logic [RIF_NCH-1:0][RIF_DW-1:0] prev;
    logic [RIF_NCH-1:0][RIF_SYNC_DLY-1:0] zdly;
    logic [RIF_NCH-1:0][RIF_ZPW-1:0] zcnt;
    logic [RIF_DW-1:0] ramp;
    logic [RIF_DW-1:0] lfsr;
    rif_word_t out;
    logic out_pend;
  } rif_st_t;

  localparam rif_st_t ST_RESET = '{
    pin_s1: '0,
    pin_s2: '0,
    sync_s1: 2'h3,
    sync_s2: 2'h3,
    prev: '0,
    zdly: '0,
    zcnt: '0,
    ramp: '0,
    lfsr: RIF_LFSR_SEED,
    out: '0,
    out_pend: 1'b0
  };

  rif_st_t st_reg;
  rif_st_t st_next;
  logic advance;
  logic fifo_in_ready;
  logic fifo_out_valid;
  rif_word_t fifo_out_word;

  // ==========================================================
  // helpers
  // channel real input: diagnostic source or desensitised port data
  function automatic logic [RIF_DW-1:0] real_input(
    input rif_chcfg_t cfg,
    input logic [RIF_DW-1:0] port,
    input logic [RIF_DW-1:0] ramp,
    input logic [RIF_DW-1:0] pn
  );
    logic [RIF_DW-1:0] noise;
    noise = pn & {{(RIF_DW - RIF_MASKW){1'b0}}, cfg.noise_mask}; // RULE_17
    if (cfg.sel == RIF_SEL_DIAG) begin
      case (cfg.diag) // RULE_19
        RIF_DIAG_RAMP: real_input = ramp;
        RIF_DIAG_CONST: real_input = RIF_CONST_VAL; // RULE_20
        RIF_DIAG_PN: real_input = pn;
        default: real_input = '0;
      endcase
    end else begin
      real_input = port ^ noise; // RULE_16
    end
  endfunction

  // I/Q placement by selector
  function automatic rif_iq_t place_iq(
    input logic [RIF_SELW-1:0] sel,
    input logic [RIF_DW-1:0] cur,
    input logic [RIF_DW-1:0] prev
  );
    place_iq = '0;
    case (sel)
      RIF_SEL_REAL, RIF_SEL_DIAG: place_iq.i = cur; // RULE_04
      RIF_SEL_IMAG: place_iq.q = cur; // RULE_06
      RIF_SEL_MUX: begin // RULE_07
        place_iq.i = prev; // RULE_08
        place_iq.q = cur; // RULE_08
      end
      default: place_iq = '0;
    endcase
  endfunction

  // galois step of the shared noise generator
  function automatic logic [RIF_DW-1:0] lfsr_step(input logic [RIF_DW-1:0] s);
    lfsr_step = s[0] ? ((s >> 1) ^ RIF_LFSR_TAPS) : (s >> 1);
  endfunction

  // ==========================================================
  // stall: a pending word that the fifo refuses freezes the whole pipe,
  // so samples arriving meanwhile are lost rather than reordered
  assign advance = ce_i && (fifo_in_ready || !st_reg.out_pend);
  assign stall_o = !advance;

  // ==========================================================
  // next state
  always_comb begin
    logic [RIF_DW-1:0] cur;
    logic sync_act;
    logic load;
    logic term;
    logic keep;
    rif_iq_t iq;
    cur = '0;
    sync_act = 1'b0;
    load = 1'b0;
    term = 1'b0;
    keep = 1'b0;
    iq = '0;
    st_next = st_reg;

    // pins pass two flops before use
    st_next.pin_s1[0] = input_port_a_i;
    st_next.pin_s1[1] = input_port_b_i;
    st_next.pin_s1[2] = input_port_c_i;
    st_next.pin_s1[3] = input_port_d_i;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.sync_s1 = {sync_input_b_n_i, sync_input_a_n_i};
    st_next.sync_s2 = st_reg.sync_s1;

    st_next.ramp = st_reg.ramp + RIF_RAMP_STEP;
    if (cksum_sync_front_i == RIF_CKS_RUN) begin
      st_next.lfsr = lfsr_step(st_reg.lfsr); // RULE_18
    end

    for (int c = 0; c < RIF_NCH; c++) begin // RULE_01
      cur = real_input(ch_cfg_i[c], st_reg.pin_s2[c], st_reg.ramp, st_reg.lfsr);
      iq = place_iq(ch_cfg_i[c].sel, cur, st_reg.prev[c]); // RULE_03
      st_next.prev[c] = cur;

      // sync pins are active low; an unused one idles high and never loads
      sync_act = !st_reg.sync_s2[ch_cfg_i[c].zsync_src]; // RULE_21
      st_next.zdly[c] = {st_reg.zdly[c][RIF_SYNC_DLY-2:0], sync_act}; // RULE_12
      load = st_reg.zdly[c][RIF_SYNC_DLY-1];
      term = (st_reg.zcnt[c] == RIF_ZCNT_TERM);
      // load and terminal reload both restart at zpad, so a periodic sync
      // at a multiple of zpad+1 lands on the phase already running
      if (load || term) begin // RULE_14
        st_next.zcnt[c] = ch_cfg_i[c].zpad; // RULE_10
      end else begin
        st_next.zcnt[c] = st_reg.zcnt[c] - RIF_ZCNT_STEP;
      end
      // unused selector codes behave like off: no word, lane stays zero
      keep = term && (ch_cfg_i[c].sel inside {RIF_SEL_IMAG, RIF_SEL_DIAG, RIF_SEL_MUX, RIF_SEL_REAL}); // RULE_11 RULE_13

      // zeroed pairs knock out the straddling (Q,I) pairs of multiplexed input
      st_next.out.vld[c] = keep; // RULE_05 RULE_09
      st_next.out.iq[c] = keep ? iq : '0; // RULE_02
    end
    st_next.out_pend = |st_next.out.vld;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= ST_RESET;
    end else if (advance) begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // output buffer
  rif_fifo #(
    .WIDTH(RIF_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .in_valid_i(st_reg.out_pend),
    .in_ready_o(fifo_in_ready),
    .in_data_i(st_reg.out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(out_ready_i),
    .out_data_o(fifo_out_word)
  );

  assign out_valid_o = fifo_out_valid;
  assign out_word_o = fifo_out_valid ? fifo_out_word : '0;

endmodule // rif_formatter

`default_nettype wire

// ==== test/rif_formatter_chk.sv ====
// checker: word layout, zero fill and back-pressure at the formatter ports
// assumes one clock domain and srst_i synchronous active high
`default_nettype none
module rif_formatter_chk #(
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire rif_pkg::rif_chcfg_t [rif_pkg::RIF_NCH-1:0] ch_cfg_i,
  input wire logic stall_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire rif_pkg::rif_word_t out_word_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import rif_pkg::*;
  // ==========================================================
  // properties
  logic fill_bad;
  always_comb begin
    fill_bad = 1'b0;
    for (int c = 0; c < RIF_NCH; c++) fill_bad |= !out_word_o.vld[c] && out_word_o.iq[c] != '0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_IDLE_ZERO: assert property (!out_valid_o |-> out_word_o == '0) else $error("word not zero while idle");
  AST_LANE_ZERO: assert property (out_valid_o |-> !fill_bad) else $error("invalid lane not zero");
  AST_REAL_Q: assert property (
    out_word_o.vld[0] && ch_cfg_i[0].sel == RIF_SEL_REAL |-> out_word_o.iq[0].q == '0) else $error("real q set");
  AST_IMAG_I: assert property (
    out_word_o.vld[1] && ch_cfg_i[1].sel == RIF_SEL_IMAG |-> out_word_o.iq[1].i == '0) else $error("imag i set");
  AST_CONST: assert property (
    out_word_o.vld[0] && ch_cfg_i[0].sel == RIF_SEL_DIAG && ch_cfg_i[0].diag == RIF_DIAG_CONST
    |-> out_word_o.iq[0] == {RIF_CONST_VAL, 16'h0000}) else $error("constant source wrong");
  AST_OFF: assert property (ch_cfg_i[3].sel == RIF_SEL_OFF |-> !out_word_o.vld[3]) else $error("off lane valid");
  AST_FREEZE: assert property (!ce_i |-> stall_o && !out_valid_o) else $error("not frozen");
  AST_HOLD: assert property (
    out_valid_o && !out_ready_i && ce_i ##1 ce_i |-> out_valid_o && $stable(out_word_o)) else $error("word not held");
  AST_RST: assert property (disable iff (1'b0) srst_i |=> !out_valid_o) else $error("valid after reset");
endmodule  // rif_formatter_chk
bind rif_formatter rif_formatter_chk #(.FIFO_DEPTH(FIFO_DEPTH)) CHK (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
  .ch_cfg_i(ch_cfg_i), .stall_o(stall_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_word_o(out_word_o));
`default_nettype wire

// ==== test/rif_adc_src.sv ====
// adc source model: four sample ports and the active-low sync pin
// assumes the bench raises sync_req_i just after a rising edge
`default_nettype none
module rif_adc_src (
  input wire logic clk_i,
  input wire logic sync_req_i,
  output logic [rif_pkg::RIF_NCH-1:0][rif_pkg::RIF_DW-1:0] port_o,
  output logic sync_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import rif_pkg::*;
  // ==========================================================
  // sample and sync drive
  logic req;
  initial begin
    port_o = '0;
    sync_n_o = 1'b1;
  end
  // bit 8 forced so a kept sample never looks like a zeroed one
  always @(posedge clk_i) begin
    req = sync_req_i;
    #1;
    for (int c = 0; c < RIF_NCH; c++) port_o[c] = RIF_DW'($urandom()) | 16'h0100;
    sync_n_o = !req;
  end
endmodule  // rif_adc_src
`default_nettype wire

// ==== test/rif_formatter_bench.sv ====
// bench: random samples through every format, ordered scoreboard on popped words
// assumes the adc source model and the checker bind are compiled with the design
`default_nettype none
module rif_formatter_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rif_pkg::*;
  // ==========================================================
  // signals, models, scoreboard
  logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, out_ready_i = 1'b1, sync_req = 1'b0;
  logic sync_a_n, stall_o, out_valid_o;
  logic [RIF_CKSW-1:0] cks = '0;
  rif_chcfg_t [RIF_NCH-1:0] cfg = '0;
  logic [RIF_NCH-1:0][RIF_DW-1:0] port;
  logic [RIF_NCH-1:0][RIF_DW-1:0] hist[$];
  rif_word_t out_word_o;
  rif_word_t exp_q[$];
  int error_cnt = 0, checks_done = 0, n = 0, s_at = -1;
  bit lead = 1'b1;
  always #2 clk_i = ~clk_i;
  rif_adc_src SRC (.clk_i(clk_i), .sync_req_i(sync_req), .port_o(port), .sync_n_o(sync_a_n));
  rif_formatter #(.FIFO_DEPTH(RIF_FIFO_DEPTH)) DUT (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .input_port_a_i(port[0]), .input_port_b_i(port[1]), .input_port_c_i(port[2]), .input_port_d_i(port[3]),
    .sync_input_a_n_i(sync_a_n), .sync_input_b_n_i(1'b1), .ch_cfg_i(cfg), .cksum_sync_front_i(cks),
    .stall_o(stall_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_word_o(out_word_o));
  function automatic rif_chcfg_t cf(input logic [RIF_SELW-1:0] s, input logic [RIF_DIAGW-1:0] d,
                                    input logic [RIF_ZPW-1:0] z, input logic [RIF_MASKW-1:0] m);
    return '{sel: s, diag: d, zpad: z, zsync_src: 1'b0, noise_mask: m};
  endfunction
  function automatic bit kept(input int k);
    int p = cfg[0].zpad + 1;
    if (s_at < 0) return cfg[0].zpad == 0;
    return k >= s_at + 2 + p && (k - s_at - 2) % p == 0;
  endfunction
  // noise generator stays at its seed while the checksum field is nonzero
  function automatic rif_word_t expect_word(input int k);
    rif_word_t w = '0;
    logic [RIF_DW-1:0] x;
    for (int c = 0; c < RIF_NCH; c++) begin
      x = hist[k][c] ^ {15'h0000, cfg[c].noise_mask[0] & (cks != '0)};
      w.vld[c] = cfg[c].sel inside {RIF_SEL_IMAG, RIF_SEL_DIAG, RIF_SEL_MUX, RIF_SEL_REAL};
      case (cfg[c].sel)
        RIF_SEL_IMAG: w.iq[c].q = x;
        RIF_SEL_DIAG: w.iq[c].i = cfg[c].diag == RIF_DIAG_CONST ? RIF_CONST_VAL : '0;
        RIF_SEL_MUX: w.iq[c] = {hist[k-1][c], x};
        RIF_SEL_REAL: w.iq[c].i = x;
        default: ;
      endcase
    end
    return w;
  endfunction
  task automatic fail(input string m);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  // leading words before the first match are pre-sync or reset leftovers
  always @(posedge clk_i) begin
    if (srst_i) begin
      hist.delete();
      exp_q.delete();
      n = 0;
      s_at = -1;
      lead = 1'b1;
    end else if (ce_i) begin
      if (out_valid_o && out_ready_i) begin
        if (exp_q.size() != 0 && out_word_o === exp_q[0]) lead = 1'b0;
        else if (!lead) fail("popped word differs");
        if (!lead) begin
          checks_done++;
          if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
      end
      if (!stall_o) begin
        hist.push_back(port);
        if (!sync_a_n && s_at < 0) s_at = n;
        if (kept(n)) exp_q.push_back(expect_word(n));
        n++;
      end
    end
  end
  task automatic run_test(input rif_chcfg_t [RIF_NCH-1:0] c, input logic [RIF_CKSW-1:0] k, input bit rnd,
                          input bit per, input string name);
    srst_i = 1'b1;
    @(posedge clk_i) #1;
    cfg = c;
    cks = k;
    @(posedge clk_i) #1;
    srst_i = 1'b0;
    for (int i = 0; i < 200; i++) begin
      sync_req = c[0].zpad != 0 && (i == 1 || per && i % 8 == 1);
      ce_i = !rnd || i < 6 || $urandom_range(0, 7) != 0;
      out_ready_i = !rnd || (!(i inside {[10:19]}) && $urandom_range(0, 3) != 0);
      @(posedge clk_i) #1;
    end
    ce_i = 1'b1;
    out_ready_i = 1'b1;
    sync_req = 1'b0;
    repeat (12) @(posedge clk_i);
    #1;
    checks_done++;
    if (lead || exp_q.size() > 8) fail("stream never aligned or words lost");
    $display("test %s done", name);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8a30));
    run_test({4{cf(RIF_SEL_REAL, '0, '0, '0)}}, '0, 1'b1, 1'b0, "real");
    run_test({cf(RIF_SEL_IMAG, '0, '0, '0), cf(RIF_SEL_REAL, '0, '0, '0), cf(RIF_SEL_IMAG, '0, '0, '0),
              cf(RIF_SEL_REAL, '0, '0, 12'hfff)}, 2'h1, 1'b1, 1'b0, "pair");
    run_test({4{cf(RIF_SEL_MUX, '0, 4'h1, '0)}}, '0, 1'b0, 1'b1, "multiplexed");
    run_test({4{cf(RIF_SEL_REAL, '0, 4'h3, '0)}}, '0, 1'b1, 1'b0, "zero insert");
    run_test({4{cf(RIF_SEL_REAL, '0, 4'hf, '0)}}, '0, 1'b0, 1'b0, "zero insert max");
    run_test({cf(RIF_SEL_OFF, '0, '0, '0), cf(3'h5, '0, '0, '0), cf(RIF_SEL_DIAG, RIF_DIAG_ZERO, '0, '0),
              cf(RIF_SEL_DIAG, RIF_DIAG_CONST, '0, '0)}, '0, 1'b1, 1'b0, "diagnostic");
    conclude();
  end
endmodule  // rif_formatter_bench
`default_nettype wire
